// *** rtl/cell_mii_port.sv ***
/*
 Cell and frame port of fast_comm_controller_one: UTOPIA slave and master receive
 and transmit octet paths, MII receive status decode, and the serial_dma_unit
 module identifier with transfer error capture.
 Assumes all port pins are synchronous to clk; the receive bus wire is resolved
 outside from rx_data_o and rx_data_oe.
*/
// What this block does
// [RQ1] Slave role: assert receive start-of-cell with the first cell byte on the bus.
// [RQ2] MII: the PHY asserts receive-valid while valid receive data is presented.
// [RQ3] MII: carrier sense without receive-valid is a broken header, not frame data.
// [RQ4] Slave role: drive cell-available only when one complete cell is ready.
// [RQ5] Master role: the PHY drives cell-available when it holds a complete cell.
// [RQ6] Master direct polling: the same pin is PHY 0 cell-available, sampled here.
// [RQ7] MII: the PHY asserts receive-error to flag a receive error.
// [RQ8] Transmit octets go out on eight bits, bit 0 least significant.
// [RQ9] With nothing queued, idle cells fill the transmit bus.
// [RQ10] Every cell across the octet buses is exactly 53 bytes from start-of-cell.
// [RQ11] Output a six-bit identifier of the controller using the serial DMA.
// [RQ12] Identifier bits 0 to 4 carry the active controller's sub-block code.
// [RQ13] Identifier bit 5 is 0 for transmit section, 1 for receive section.
// [RQ14] Capture the identifier of a failing transfer into the error register.
// [RQ15] Receive enable in a cycle makes the bus valid in the next cycle.
// [RQ16] Drive the receive octet bus only in the cycle after receive enable is asserted.
// [RQ17] All handshake and data signals are driven and sampled on rising clk; rx_enable_o_n and tx_src_ready are combinational from rx_clav_i and tx_enable_n.
`timescale 1ns/100ps
module cell_mii_port
  import cell_port_pkg::*;
#(
  parameter int unsigned byte_width = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire port_mode_e mode,
  // Cell source toward the slave receive bus.
  input wire octet_s cell_in,
  input wire logic cell_in_valid,
  output logic cell_in_ready,
  input wire logic cell_in_ready_full,
  // Transmit octet source from the controller.
  input wire logic [byte_width-1:0] tx_src_data,
  input wire logic tx_src_valid,
  output logic tx_src_ready,
  // UTOPIA pins.
  input wire logic rx_enable_n,
  output logic [byte_width-1:0] rx_data_o,
  output logic rx_data_oe,
  output logic rx_soc_o,
  output logic rx_clav_o,
  input wire logic rx_clav_i,
  input wire logic [byte_width-1:0] rx_data_i,
  input wire logic rx_soc_i,
  output logic rx_enable_o_n,
  input wire logic tx_enable_n,
  output logic [byte_width-1:0] tx_data,
  output logic tx_soc,
  // Received master-role octets.
  output octet_s rx_octet,
  output logic rx_octet_valid,
  // MII receive status.
  input wire logic mii_crs,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  output logic mii_frame_active,
  output logic mii_broken_header,
  output logic mii_rx_error,
  // Serial DMA identifier.
  input wire dma_id_s dma_id_in,
  input wire logic dma_fail,
  input wire logic dma_err_clear,
  output logic [5:0] dma_module_identifier,
  output dma_id_s dma_err_id,
  output logic dma_err_valid
);

  // Steps the cell byte index and wraps from the last byte back to the start-of-cell slot.
  function automatic logic [5:0] cell_step(input logic [5:0] idx);
    cell_step = (idx == cell_last_idx) ? 6'h00 : idx + 6'h01;
  endfunction

  // Two-entry buffer in the slave receive path; a paused PHY loses no byte.
  octet_s buf_reg [2];
  octet_s buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic buf_pop;
  // Ready ignores a pop in the same cycle. A full buffer loses a cycle of rate, but ready
  // then never depends on the enable pin.
  assign cell_in_ready = (cnt_reg != 2'h2);
  assign buf_pop = (mode == mode_utopia_slave) && !rx_enable_n && (cnt_reg != 2'h0); // [RQ15]

  always_comb begin
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    if (buf_pop) begin
      buf_next[0] = buf_reg[1];
      cnt_next = cnt_next - 2'h1;
    end
    if (cell_in_valid && cell_in_ready) begin
      buf_next[cnt_next[0]] = cell_in;
      cnt_next = cnt_next + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin // [RQ17]
    if (!resetn) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      cnt_reg <= 2'h0;
    end else begin
      buf_reg <= buf_next;
      cnt_reg <= cnt_next;
    end
  end

  // Slave receive pins: bus driven the cycle after enable is seen low.
  // An enable that finds the buffer empty still drives the bus, with stale data and no
  // start-of-cell, so the source must raise cell-available only for whole cells.
  logic [7:0] rxo_reg, rxo_next;
  logic soc_reg, soc_next, oe_reg, oe_next, clav_reg, clav_next;
  always_comb begin
    rxo_next = rxo_reg;
    soc_next = 1'b0;
    oe_next = (mode == mode_utopia_slave) && !rx_enable_n; // [RQ16]
    clav_next = (mode == mode_utopia_slave) && cell_in_ready_full; // [RQ4]
    if (buf_pop) begin
      rxo_next = buf_reg[0].data;
      soc_next = buf_reg[0].first; // [RQ1]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxo_reg <= 8'h00;
      soc_reg <= 1'b0;
      oe_reg <= 1'b0;
      clav_reg <= 1'b0;
    end else begin
      rxo_reg <= rxo_next;
      soc_reg <= soc_next;
      oe_reg <= oe_next;
      clav_reg <= clav_next;
    end
  end
  assign rx_data_o = rxo_reg;
  assign rx_data_oe = oe_reg;
  assign rx_soc_o = soc_reg && oe_reg;
  assign rx_clav_o = clav_reg;

  // Master receive: enable while PHY 0 shows cell-available, sample one cycle later.
  // Enable is not registered: lagging a cycle behind cell-available would pull a stray
  // octet from a PHY that has already finished its cell.
  logic en_now, samp_reg, samp_next, rv_reg, rv_next;
  octet_s ro_reg, ro_next;
  assign en_now = (mode == mode_utopia_master) && rx_clav_i; // [RQ5] [RQ6]
  always_comb begin
    samp_next = en_now; // [RQ15]
    rv_next = samp_reg;
    ro_next = ro_reg;
    if (samp_reg) begin
      ro_next.data = rx_data_i;
      ro_next.first = rx_soc_i;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_reg <= 1'b0;
      rv_reg <= 1'b0;
      ro_reg <= '0;
    end else begin
      samp_reg <= samp_next;
      rv_reg <= rv_next;
      ro_reg <= ro_next;
    end
  end
  assign rx_enable_o_n = !en_now;
  assign rx_octet = ro_reg;
  assign rx_octet_valid = rv_reg;

  // Transmit: 53-byte cells, idle cells when the source has nothing whole.
  // Real or idle is chosen once, at the start-of-cell slot; a source that runs dry
  // in mid-cell is not covered and must supply all bytes of a real cell.
  logic [5:0] tidx_reg, tidx_next;
  logic idle_reg, idle_next, tsoc_reg, tsoc_next;
  logic [7:0] txd_reg, txd_next;
  logic tx_go;
  assign tx_go = (mode != mode_mii) && !tx_enable_n;
  // Ready pulses for each byte of a real cell and stays low through an idle cell.
  assign tx_src_ready = tx_go && !((tidx_reg == 6'h00) ? !tx_src_valid : idle_reg);

  always_comb begin
    tidx_next = tidx_reg;
    idle_next = idle_reg;
    txd_next = txd_reg;
    tsoc_next = 1'b0;
    if (tx_go) begin
      if (tidx_reg == 6'h00) begin
        idle_next = !tx_src_valid; // [RQ9]
        tsoc_next = 1'b1;
      end
      if ((tidx_reg == 6'h00) ? tx_src_valid : !idle_reg) begin
        txd_next = tx_src_data; // [RQ8]
      end else if (tidx_reg < idle_last_hdr_idx) begin
        txd_next = idle_header_byte;
      end else if (tidx_reg == idle_last_hdr_idx) begin
        txd_next = idle_last_header;
      end else begin
        txd_next = idle_payload_byte;
      end
      tidx_next = cell_step(tidx_reg); // [RQ10]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tidx_reg <= 6'h00;
      idle_reg <= 1'b1;
      tsoc_reg <= 1'b0;
      txd_reg <= 8'h00;
    end else begin
      tidx_reg <= tidx_next;
      idle_reg <= idle_next;
      tsoc_reg <= tsoc_next;
      txd_reg <= txd_next;
    end
  end
  assign tx_data = txd_reg;
  assign tx_soc = tsoc_reg;

  // MII receive status decode.
  // Receive-valid outranks carrier sense, so carrier alone marks a broken header.
  // The flags follow the pins one cycle late and are not held.
  mii_state_e mii_reg, mii_next;
  logic er_reg, er_next;
  always_comb begin
    mii_next = mii_idle;
    er_next = 1'b0;
    if (mode == mode_mii) begin
      if (mii_rx_dv) begin
        mii_next = mii_frame; // [RQ2]
      end else if (mii_crs) begin
        mii_next = mii_broken; // [RQ3]
      end
      er_next = mii_rx_er; // [RQ7]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mii_reg <= mii_idle;
      er_reg <= 1'b0;
    end else begin
      mii_reg <= mii_next;
      er_reg <= er_next;
    end
  end

  always_comb begin
    mii_frame_active = 1'b0;
    mii_broken_header = 1'b0;
    case (mii_reg)
      mii_frame: mii_frame_active = 1'b1;
      mii_broken: mii_broken_header = 1'b1;
      default: mii_frame_active = 1'b0;
    endcase
  end
  assign mii_rx_error = er_reg;

  // Serial DMA identifier and first-error capture; a new failure wins over clear.
  // The identifier is registered so that it only changes on clock edges.
  // The error register keeps the first failure until software clears it.
  dma_id_s id_reg, id_next, eid_reg, eid_next;
  logic ev_reg, ev_next;
  always_comb begin
    id_next = dma_id_in; // [RQ12] [RQ13]
    eid_next = eid_reg;
    ev_next = ev_reg && !dma_err_clear;
    if (dma_fail && (!ev_reg || dma_err_clear)) begin
      eid_next = dma_id_in; // [RQ14]
      ev_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      id_reg <= '0;
      eid_reg <= '0;
      ev_reg <= 1'b0;
    end else begin
      id_reg <= id_next;
      eid_reg <= eid_next;
      ev_reg <= ev_next;
    end
  end
  always_comb begin
    dma_module_identifier = '0;
    dma_module_identifier[sub_block_msb:sub_block_lsb] = id_reg.sub_block; // [RQ11]
    dma_module_identifier[section_bit] = id_reg.section;
  end
  assign dma_err_id = eid_reg;
  assign dma_err_valid = ev_reg;

endmodule // cell_mii_port

// *** rtl/cell_port_pkg.sv ***
/*
 Shared constants, enumerations and carriers for the cell and frame port.
 Assumes a single 100 MHz clock domain and an active-low asynchronous reset.
*/
package cell_port_pkg;
  localparam int unsigned cell_bytes = 53;
  localparam logic [5:0] cell_last_idx = 6'h34;
  localparam logic [7:0] idle_header_byte = 8'h00;
  localparam logic [7:0] idle_last_header = 8'h01;
  localparam logic [5:0] idle_last_hdr_idx = 6'h03;
  localparam logic [7:0] idle_payload_byte = 8'h6a;
  localparam int unsigned sub_block_lsb = 0;
  localparam int unsigned sub_block_msb = 4;
  localparam int unsigned section_bit = 5;
  localparam logic section_transmit = 1'b0;
  localparam logic section_receive = 1'b1;

  typedef enum logic [1:0] {
    mode_utopia_slave,
    mode_utopia_master,
    mode_mii
  } port_mode_e;

  typedef enum logic [1:0] {
    mii_idle,
    mii_frame,
    mii_broken
  } mii_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic first;
  } octet_s;

  typedef struct packed {
    logic [4:0] sub_block;
    logic section;
  } dma_id_s;
endpackage

// *** dv/cell_mii_port_props.sv ***
/* Pin timing checker for the cell and frame port.
 Assumes it is bound onto the port's top module and sees its ports only. */
`timescale 1ns/100ps
module cell_mii_port_props
  import cell_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire port_mode_e mode,
  input wire logic cell_in_ready_full,
  input wire logic rx_enable_n,
  input wire logic rx_data_oe,
  input wire logic rx_soc_o,
  input wire logic rx_clav_o,
  input wire logic rx_clav_i,
  input wire logic rx_enable_o_n,
  input wire logic rx_octet_valid,
  input wire logic tx_enable_n,
  input wire logic tx_soc,
  input wire logic mii_crs,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  input wire logic mii_frame_active,
  input wire logic mii_broken_header,
  input wire logic mii_rx_error,
  input wire dma_id_s dma_id_in,
  input wire logic dma_fail,
  input wire logic [5:0] dma_module_identifier,
  input wire logic dma_err_valid
);
  wire sl = mode == mode_utopia_slave;
  wire ms = mode == mode_utopia_master;
  wire mi = mode == mode_mii;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_bus_driven: assert property (sl && !rx_enable_n |=> rx_data_oe) else $error("bus not driven");
  a_bus_released: assert property (rx_enable_n |=> !rx_data_oe) else $error("bus not released");
  a_soc_on_bus: assert property (rx_soc_o |-> rx_data_oe) else $error("soc off bus");
  a_clav_follows: assert property (sl |=> rx_clav_o == $past(cell_in_ready_full)) else $error("clav");
  a_master_enable: assert property (ms && rx_clav_i |-> !rx_enable_o_n) else $error("no enable");
  a_enable_needs_clav: assert property (ms && !rx_clav_i |-> rx_enable_o_n) else $error("stray enable");
  a_octet_taken: assert property (ms && !rx_enable_o_n |-> ##2 rx_octet_valid) else $error("no octet");
  a_tx_soc_once: assert property (tx_soc && !tx_enable_n && !mi |=> !tx_soc) else $error("soc twice");
  a_mii_broken: assert property (mi && mii_crs && !mii_rx_dv |=> mii_broken_header && !mii_frame_active)
    else $error("broken header");
  a_mii_error: assert property (mi && mii_rx_er |=> mii_rx_error) else $error("rx error");
  a_dma_ident: assert property ($past(resetn) |-> dma_module_identifier ==
    {$past(dma_id_in.section), $past(dma_id_in.sub_block)}) else $error("identifier");
  a_err_capture: assert property (dma_fail && !dma_err_valid |=> dma_err_valid) else $error("capture");
  c_slave_pop: cover property (rx_soc_o);
  c_master_octet: cover property (rx_octet_valid);
  c_tx_cell: cover property (tx_soc);
endmodule // cell_mii_port_props

// *** dv/utopia_phy_model.sv ***
/* Receive-side UTOPIA PHY facing a master-role port: one cell of 53 bytes.
 Assumes have_cell is a level from the bench, dropped to stall the transfer. */
`timescale 1ns/100ps
module utopia_phy_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic have_cell,
  input wire logic rx_enable_o_n,
  output logic rx_clav_i,
  output logic [7:0] rx_data_i,
  output logic rx_soc_i
);
  logic [5:0] idx;
  logic done;
  // Cell-available drops once the whole cell has gone, so a cell is never cut.
  assign rx_clav_i = have_cell && !done;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx <= 6'h00;
      done <= 1'h0;
      rx_data_i <= 8'h00;
      rx_soc_i <= 1'h0;
    end else if (!rx_enable_o_n && !done) begin
      rx_data_i <= 8'h10 + {2'h0, idx};
      rx_soc_i <= idx == 6'h00;
      idx <= idx + 6'h01;
      done <= idx == 6'h34;
    end else begin
      // An unselected bus must not look like it still holds the last byte.
      rx_data_i <= ~rx_data_i;
      rx_soc_i <= 1'h0;
    end
  end
endmodule // utopia_phy_model

// *** dv/cell_mii_port_tb.sv ***
/* Self-checking bench for the cell and frame port, one task per scenario.
 Assumes the receive PHY model and the pin checker sit beside the port. */
`timescale 1ns/100ps
module cell_mii_port_tb;
  import cell_port_pkg::*;
  logic clk = 1'h0;
  logic resetn, cell_in_valid, cell_in_ready, cell_in_ready_full, tx_src_valid, tx_src_ready, rx_enable_n;
  logic rx_data_oe, rx_soc_o, rx_clav_o, rx_clav_i, rx_soc_i, rx_enable_o_n, tx_enable_n, tx_soc, have_cell;
  logic rx_octet_valid, mii_crs, mii_rx_dv, mii_rx_er, mii_frame_active, mii_broken_header, mii_rx_error;
  logic dma_fail, dma_err_clear, dma_err_valid;
  logic [7:0] tx_src_data, rx_data_o, rx_data_i, tx_data;
  logic [5:0] dma_module_identifier;
  port_mode_e mode;
  octet_s cell_in, rx_octet;
  dma_id_s dma_id_in, dma_err_id;
  int miscompares, n_compared;
  always #5 clk = ~clk;
  logic tx_took;
  // The source steps to its next byte on the falling edge after a byte is taken.
  always @(posedge clk) tx_took <= tx_src_valid && tx_src_ready;
  always @(negedge clk) begin
    if (!resetn) tx_src_data <= 8'h80;
    else if (tx_took) tx_src_data <= tx_src_data + 8'h01;
  end
  cell_mii_port i_cell_mii_port (
    .clk(clk), .resetn(resetn), .mode(mode), .cell_in(cell_in), .cell_in_valid(cell_in_valid),
    .cell_in_ready(cell_in_ready), .cell_in_ready_full(cell_in_ready_full), .tx_src_data(tx_src_data),
    .tx_src_valid(tx_src_valid), .tx_src_ready(tx_src_ready), .rx_enable_n(rx_enable_n),
    .rx_data_o(rx_data_o), .rx_data_oe(rx_data_oe), .rx_soc_o(rx_soc_o), .rx_clav_o(rx_clav_o),
    .rx_clav_i(rx_clav_i), .rx_data_i(rx_data_i), .rx_soc_i(rx_soc_i), .rx_enable_o_n(rx_enable_o_n),
    .tx_enable_n(tx_enable_n), .tx_data(tx_data), .tx_soc(tx_soc), .rx_octet(rx_octet),
    .rx_octet_valid(rx_octet_valid), .mii_crs(mii_crs), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_frame_active(mii_frame_active), .mii_broken_header(mii_broken_header), .mii_rx_error(mii_rx_error),
    .dma_id_in(dma_id_in), .dma_fail(dma_fail), .dma_err_clear(dma_err_clear),
    .dma_module_identifier(dma_module_identifier), .dma_err_id(dma_err_id), .dma_err_valid(dma_err_valid)
  );
  utopia_phy_model i_utopia_phy_model (
    .clk(clk), .resetn(resetn), .have_cell(have_cell), .rx_enable_o_n(rx_enable_o_n),
    .rx_clav_i(rx_clav_i), .rx_data_i(rx_data_i), .rx_soc_i(rx_soc_i)
  );
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset(input port_mode_e m);
    @(negedge clk);
    resetn = 1'h0;
    mode = m;
    repeat (6) @(negedge clk);
    resetn = 1'h1;
  endtask
  task automatic t_slave;
    do_reset(mode_utopia_slave);
    cell_in_ready_full = 1'h1;
    fork
      begin
        for (int i = 0; i < 53; i++) begin
          @(negedge clk);
          cell_in.data = 8'h40 + i[7:0];
          cell_in.first = i == 0;
          cell_in_valid = 1'h1;
          // Ready only moves on rising edges, so the value seen here is what the next edge takes.
          while (!cell_in_ready) @(negedge clk);
          @(posedge clk);
        end
        @(negedge clk);
        cell_in_valid = 1'h0;
      end
      begin
        repeat (3) @(negedge clk);
        chk(rx_clav_o, 9'h001);
        for (int i = 0; i < 53; i++) begin
          rx_enable_n = 1'h0;
          @(negedge clk);
          rx_enable_n = 1'h1;
          chk({rx_data_oe, rx_data_o}, {1'h1, 8'h40 + i[7:0]});
          chk(rx_soc_o, i == 0);
          @(negedge clk);
          chk(rx_data_oe, 9'h000);
        end
      end
    join
  endtask
  task automatic t_dma;
    dma_id_in = '{5'h15, 1'h1};
    @(negedge clk);
    chk(dma_module_identifier, 9'h035);
    dma_id_in = '{5'h0a, 1'h0};
    @(negedge clk);
    chk(dma_module_identifier, 9'h00a);
    dma_fail = 1'h1;
    @(negedge clk);
    dma_id_in = '{5'h15, 1'h1};
    @(negedge clk);
    chk({dma_err_valid, dma_err_id}, 9'h054);
    @(negedge clk);
    dma_fail = 1'h0;
    chk({dma_err_valid, dma_err_id}, 9'h054);
    dma_err_clear = 1'h1;
    @(negedge clk);
    dma_err_clear = 1'h0;
    @(negedge clk);
    chk(dma_err_valid, 9'h000);
    // A new failure in the cycle of a clear is kept, not wiped by the clear.
    dma_fail = 1'h1;
    @(negedge clk);
    dma_id_in = '{5'h0a, 1'h0};
    dma_err_clear = 1'h1;
    @(negedge clk);
    {dma_fail, dma_err_clear} = 2'h0;
    chk({dma_err_valid, dma_err_id}, 9'h054);
  endtask
  task automatic t_master;
    int k;
    do_reset(mode_utopia_master);
    have_cell = 1'h1;
    k = 0;
    for (int c = 0; c < 300 && k < 53; c++) begin
      @(negedge clk);
      // A slow PHY withdraws cell-available for a few cycles mid-cell.
      have_cell = !(c >= 20 && c < 25);
      if (rx_octet_valid) begin
        chk(rx_octet, {8'h10 + k[7:0], k == 0});
        k++;
      end
    end
    chk(k[8:0], 9'h035);
    repeat (4) begin
      @(negedge clk);
      chk(rx_octet_valid, 9'h000);
    end
    have_cell = 1'h0;
  endtask
  task automatic tx_cell(input logic real_cell);
    int n;
    logic [7:0] e;
    n = 0;
    while (!tx_soc && n < 200) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 53; i++) begin
      e = real_cell ? 8'h80 + i[7:0] : i < 3 ? 8'h00 : i == 3 ? 8'h01 : 8'h6a;
      chk({tx_soc, tx_data}, {i == 0, e});
      if (!real_cell && i > 10 && i < 52) chk(tx_src_ready, 9'h000);
      if (i == 10) tx_src_valid = 1'h1;
      @(negedge clk);
    end
  endtask
  task automatic t_mii;
    do_reset(mode_mii);
    mii_crs = 1'h1;
    @(negedge clk);
    chk({mii_broken_header, mii_frame_active}, 9'h002);
    mii_rx_dv = 1'h1;
    mii_rx_er = 1'h1;
    @(negedge clk);
    chk({mii_broken_header, mii_frame_active, mii_rx_error}, 9'h003);
  endtask
  initial begin
    {resetn, cell_in, cell_in_valid, cell_in_ready_full, tx_src_valid, have_cell} = '0;
    {mii_crs, mii_rx_dv, mii_rx_er, dma_id_in, dma_fail, dma_err_clear} = '0;
    {rx_enable_n, tx_enable_n} = 2'h3;
    mode = mode_utopia_slave;
    t_slave();
    t_dma();
    t_master();
    do_reset(mode_utopia_slave);
    tx_enable_n = 1'h0;
    tx_cell(1'h0);
    tx_cell(1'h1);
    tx_enable_n = 1'h1;
    t_mii();
    stop_test();
  end
  initial begin
    #20us;
    miscompares++;
    stop_test();
  end
endmodule // cell_mii_port_tb
bind cell_mii_port cell_mii_port_props i_cell_mii_port_props (
  .clk(clk), .resetn(resetn), .mode(mode), .cell_in_ready_full(cell_in_ready_full),
  .rx_enable_n(rx_enable_n), .rx_data_oe(rx_data_oe), .rx_soc_o(rx_soc_o), .rx_clav_o(rx_clav_o),
  .rx_clav_i(rx_clav_i), .rx_enable_o_n(rx_enable_o_n), .rx_octet_valid(rx_octet_valid),
  .tx_enable_n(tx_enable_n), .tx_soc(tx_soc), .mii_crs(mii_crs), .mii_rx_dv(mii_rx_dv),
  .mii_rx_er(mii_rx_er), .mii_frame_active(mii_frame_active), .mii_broken_header(mii_broken_header),
  .mii_rx_error(mii_rx_error), .dma_id_in(dma_id_in), .dma_fail(dma_fail),
  .dma_module_identifier(dma_module_identifier), .dma_err_valid(dma_err_valid)
);
